// file: inc/rcp_pkg.sv
// Constants for the reset cause and part identification bank.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package rcp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int              ADDR_W          = 8;
   localparam int              DATA_W          = 32;
   localparam int              STRB_W          = DATA_W / 8;
   localparam int              BYTE_W          = 8;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]      OFS_PART_ID     = 8'h00;
   localparam logic [7:0]      OFS_CAUSE       = 8'h04;
   localparam logic [7:0]      OFS_PERIPH_RST  = 8'h08;
   localparam logic [7:0]      OFS_IRQ_STATUS  = 8'h0c;
   localparam logic [7:0]      OFS_IRQ_MASK    = 8'h10;
   localparam int              WORD_LSB        = 2;

   ////////////////////////////////////////////////////////////////////////////
   localparam int              FLAG_W          = 8;
   localparam int              BIT_POWER_ON    = 0;
   localparam int              BIT_EXT_PIN     = 1;
   localparam int              BIT_WATCHDOG    = 2;
   localparam int              BIT_LOW_VOLT    = 3;
   localparam int              BIT_BROWNOUT    = 4;
   localparam int              BIT_SYS_REQ     = 5;
   localparam int              BIT_CORE        = 7;
   localparam logic [7:0]      FLAG_USED_MASK  = 8'hbf;
   localparam logic [7:0]      FLAG_POR_VALUE  = 8'h01;
   localparam logic [7:0]      FLAG_CLEAR      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   localparam int              CTRL_W          = 2;
   localparam int              BIT_CHIP_RST    = 0;
   localparam int              BIT_CORE_RST    = 1;

   ////////////////////////////////////////////////////////////////////////////
   localparam int              CLK_MHZ         = 50;
   localparam int              ONE_SHOT_CYCLES = 2;
   localparam int              CNT_W           = 2;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [1:0]      RESP_OKAY       = 2'h0;
   localparam logic [1:0]      RESP_SLVERR     = 2'h2;

   // Arbitrary identification value, not tied to any real part
   localparam logic [31:0]     PART_ID_DEFAULT = 32'h0000_0a5a;

endpackage : rcp_pkg

// file: rtl/rcp_oneshot.sv
// One-shot pulse stretcher for the core reset control bit.
// Assumes start is a single-cycle pulse synchronous to sys_clk.
`timescale 1ns/100ps
module rcp_oneshot #(
   parameter int CYCLES = rcp_pkg::ONE_SHOT_CYCLES
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic                     start,
   output logic                          active
);
   import rcp_pkg::*;

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_count = count;
      if (start) begin
         next_count = CNT_W'(CYCLES);
      end else if (count != '0) begin
         next_count = count - CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign active = (count != '0);

endmodule : rcp_oneshot

// file: rtl/rcp_axi_slave.sv
// AXI4-Lite slave front end: one read in flight at a time; a second write may be held while a response waits.
// Assumes the register core decodes addresses and returns read data combinationally.
`timescale 1ns/100ps
module rcp_axi_slave #(
   parameter int ADDR_W = rcp_pkg::ADDR_W
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic [ADDR_W-1:0]        s_awaddr,
   input  wire logic                     s_awvalid,
   output logic                          s_awready,
   input  wire logic [rcp_pkg::DATA_W-1:0] s_wdata,
   input  wire logic [rcp_pkg::STRB_W-1:0] s_wstrb,
   input  wire logic                     s_wvalid,
   output logic                          s_wready,
   output logic [1:0]                    s_bresp,
   output logic                          s_bvalid,
   input  wire logic                     s_bready,
   input  wire logic [ADDR_W-1:0]        s_araddr,
   input  wire logic                     s_arvalid,
   output logic                          s_arready,
   output logic [rcp_pkg::DATA_W-1:0]    s_rdata,
   output logic [1:0]                    s_rresp,
   output logic                          s_rvalid,
   input  wire logic                     s_rready,
   output logic                          wr_en,
   output logic [ADDR_W-1:0]             wr_addr,
   output logic [rcp_pkg::DATA_W-1:0]    wr_data,
   output logic [rcp_pkg::STRB_W-1:0]    wr_strb,
   input  wire logic                     wr_err,
   output logic [ADDR_W-1:0]             rd_addr,
   input  wire logic [rcp_pkg::DATA_W-1:0] rd_data,
   input  wire logic                     rd_err
);
   import rcp_pkg::*;

   logic              aw_full, next_aw_full, w_full, next_w_full;
   logic [ADDR_W-1:0] next_wr_addr;
   logic [DATA_W-1:0] next_wr_data, next_rdata;
   logic [STRB_W-1:0] next_wr_strb;
   logic              next_bvalid, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;

   ////////////////////////////////////////////////////////////////////////////
   assign s_awready = !aw_full;
   assign s_wready  = !w_full;
   assign s_arready = !s_rvalid;
   assign wr_en     = aw_full && w_full && !s_bvalid;
   assign rd_addr   = s_araddr;

   always_comb begin
      next_aw_full = aw_full;
      next_w_full  = w_full;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid  = s_bvalid;
      next_bresp   = s_bresp;
      next_rvalid  = s_rvalid;
      next_rdata   = s_rdata;
      next_rresp   = s_rresp;
      if (s_awvalid && s_awready) begin
         next_aw_full = 1'b1;
         next_wr_addr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         next_w_full  = 1'b1;
         next_wr_data = s_wdata;
         next_wr_strb = s_wstrb;
      end
      if (wr_en) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bready) begin
         next_bvalid  = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_data;
         next_rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         aw_full  <= 1'b0;
         w_full   <= 1'b0;
         wr_addr  <= '0;
         wr_data  <= '0;
         wr_strb  <= '0;
         s_bvalid <= 1'b0;
         s_bresp  <= RESP_OKAY;
         s_rvalid <= 1'b0;
         s_rdata  <= '0;
         s_rresp  <= RESP_OKAY;
      end else begin
         aw_full  <= next_aw_full;
         w_full   <= next_w_full;
         wr_addr  <= next_wr_addr;
         wr_data  <= next_wr_data;
         wr_strb  <= next_wr_strb;
         s_bvalid <= next_bvalid;
         s_bresp  <= next_bresp;
         s_rvalid <= next_rvalid;
         s_rdata  <= next_rdata;
         s_rresp  <= next_rresp;
      end
   end

endmodule : rcp_axi_slave

// file: rtl/rcp_top.sv
// Reset cause flags and part identification register bank.
// Assumes reset sources arrive as levels synchronous to sys_clk while they act,
// and por_rstn comes only from the power-on controller.
//
// Summary of operation
// [RULE1] Identification register returns a fixed 32-bit part code; writes ignored.
// [RULE2] Writing one to core one-shot reset control sets core reset flag, bit 7.
// [RULE3] Processor system reset request sets system request flag, bit 5.
// [RULE4] Brown-out detector reset sets brown-out flag, bit 4.
// [RULE5] Low-voltage detector reset sets low-voltage flag, bit 3.
// [RULE6] Flags clear only by writing one; writing zero keeps them.
// [RULE7] Watchdog or window watchdog reset sets watchdog flag, bit 2.
// [RULE8] External reset pin sets external pin flag, bit 1.
// [RULE9] Power-on or whole-chip software reset sets power-on flag, bit 0.
// [RULE10] Core one-shot control self-clears after two cycles; resets core and flash only.
// [RULE11] Reserved bits read zero; flags survive the resets they record.
`timescale 1ns/100ps
module rcp_top #(
   parameter int                ADDR_W  = rcp_pkg::ADDR_W,
   parameter logic [31:0]       PART_ID = rcp_pkg::PART_ID_DEFAULT
) (
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   input  wire logic                       por_rstn,
   input  wire logic [ADDR_W-1:0]          s_awaddr,
   input  wire logic                       s_awvalid,
   output logic                            s_awready,
   input  wire logic [rcp_pkg::DATA_W-1:0] s_wdata,
   input  wire logic [rcp_pkg::STRB_W-1:0] s_wstrb,
   input  wire logic                       s_wvalid,
   output logic                            s_wready,
   output logic [1:0]                      s_bresp,
   output logic                            s_bvalid,
   input  wire logic                       s_bready,
   input  wire logic [ADDR_W-1:0]          s_araddr,
   input  wire logic                       s_arvalid,
   output logic                            s_arready,
   output logic [rcp_pkg::DATA_W-1:0]      s_rdata,
   output logic [1:0]                      s_rresp,
   output logic                            s_rvalid,
   input  wire logic                       s_rready,
   input  wire logic                       system_reset_request,
   input  wire logic                       brownout_reset,
   input  wire logic                       low_voltage_reset,
   input  wire logic                       watchdog_reset,
   input  wire logic                       window_watchdog_reset,
   input  wire logic                       external_pin_reset,
   output logic                            core_flash_reset,
   output logic                            chip_reset_request,
   output logic                            irq
);
   import rcp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the read and write paths
   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      logic [7:0] ofs;
      ofs = 8'(addr);
      is_mapped = (ofs == OFS_PART_ID) || (ofs == OFS_CAUSE) ||
                  (ofs == OFS_PERIPH_RST) || (ofs == OFS_IRQ_STATUS) ||
                  (ofs == OFS_IRQ_MASK);
   endfunction : is_mapped

   function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                 input logic [7:0]        ofs);
      hits = (8'(addr) == ofs);
   endfunction : hits

   // Byte-lane merge for plain read/write registers
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_val,
                                               input logic [DATA_W-1:0] new_val,
                                               input logic [STRB_W-1:0] strb);
      merge = old_val;
      for (int i = 0; i < STRB_W; i++) begin
         if (strb[i]) begin
            merge[i*BYTE_W +: BYTE_W] = new_val[i*BYTE_W +: BYTE_W];
         end
      end
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////
   logic                wr_en;
   logic [ADDR_W-1:0]   wr_addr;
   logic [DATA_W-1:0]   wr_data;
   logic [STRB_W-1:0]   wr_strb;
   logic [ADDR_W-1:0]   rd_addr;
   logic [DATA_W-1:0]   rd_data;
   logic [DATA_W-1:0]   low_lane;

   logic [FLAG_W-1:0]   cause_flags;
   logic [FLAG_W-1:0]   next_cause_flags;
   logic [FLAG_W-1:0]   irq_status;
   logic [FLAG_W-1:0]   next_irq_status;
   logic [FLAG_W-1:0]   irq_mask;
   logic [FLAG_W-1:0]   next_irq_mask;
   logic [FLAG_W-1:0]   set_vec;
   logic [FLAG_W-1:0]   cause_clr;
   logic [FLAG_W-1:0]   status_clr;
   logic                chip_req;
   logic                next_chip_req;
   logic                core_start;
   logic                chip_start;
   logic [CTRL_W-1:0]   ctrl_view;

   ////////////////////////////////////////////////////////////////////////////
   rcp_axi_slave #(
      .ADDR_W    (ADDR_W)
   ) u_bus (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_err    (!is_mapped(wr_addr)),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_err    (!is_mapped(rd_addr))
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write side effects
   // Only the low byte lane carries flag and control bits
   assign low_lane   = wr_strb[0] ? wr_data : '0;
   assign core_start = wr_en && hits(wr_addr, OFS_PERIPH_RST) &&
                       low_lane[BIT_CORE_RST];
   assign chip_start = wr_en && hits(wr_addr, OFS_PERIPH_RST) &&
                       low_lane[BIT_CHIP_RST];
   assign cause_clr  = (wr_en && hits(wr_addr, OFS_CAUSE)) ?
                       FLAG_W'(low_lane) & FLAG_USED_MASK : FLAG_CLEAR; // see [RULE6]
   assign status_clr = (wr_en && hits(wr_addr, OFS_IRQ_STATUS)) ?
                       FLAG_W'(low_lane) & FLAG_USED_MASK : FLAG_CLEAR;

   ////////////////////////////////////////////////////////////////////////////
   // Core one-shot reset; the bit reads back while the pulse runs
   rcp_oneshot #(
      .CYCLES  (ONE_SHOT_CYCLES)
   ) u_core_pulse (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .start   (core_start),
      .active  (core_flash_reset)
   ); // see [RULE10]

   // Whole-chip reset request is a single-cycle pulse and reads as zero
   always_comb begin
      next_chip_req = chip_start;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         chip_req <= 1'b0;
      end else begin
         chip_req <= next_chip_req;
      end
   end

   assign chip_reset_request = chip_req;

   always_comb begin
      ctrl_view               = '0;
      ctrl_view[BIT_CORE_RST] = core_flash_reset;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event vector in flag layout
   always_comb begin
      set_vec               = '0;
      set_vec[BIT_CORE]     = core_start;                                   // see [RULE2]
      set_vec[BIT_SYS_REQ]  = system_reset_request;                         // see [RULE3]
      set_vec[BIT_BROWNOUT] = brownout_reset;                               // see [RULE4]
      set_vec[BIT_LOW_VOLT] = low_voltage_reset;                            // see [RULE5]
      set_vec[BIT_WATCHDOG] = watchdog_reset || window_watchdog_reset;      // see [RULE7]
      set_vec[BIT_EXT_PIN]  = external_pin_reset;                           // see [RULE8]
      set_vec[BIT_POWER_ON] = chip_start;                                   // see [RULE9]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cause flags: a set in the same cycle as a clear wins
   genvar g;
   generate
      for (g = 0; g < FLAG_W; g++) begin : g_flag
         always_comb begin
            if (FLAG_USED_MASK[g]) begin
               next_cause_flags[g] = set_vec[g] || (cause_flags[g] && !cause_clr[g]); // see [RULE6]
               next_irq_status[g]  = set_vec[g] || (irq_status[g] && !status_clr[g]);
            end else begin
               next_cause_flags[g] = 1'b0;                                  // see [RULE11]
               next_irq_status[g]  = 1'b0;
            end
         end
      end
   endgenerate

   // Kept off rstn so core, pin, watchdog and brown-out resets leave them intact;
   // only power-on clears them, and it records itself on the way out
   always_ff @(posedge sys_clk or negedge por_rstn) begin
      if (!por_rstn) begin
         cause_flags <= FLAG_POR_VALUE;                                     // see [RULE9]
         irq_status  <= FLAG_POR_VALUE;
      end else begin
         cause_flags <= next_cause_flags;                                   // see [RULE11]
         irq_status  <= next_irq_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt mask
   always_comb begin
      next_irq_mask = irq_mask;
      if (wr_en && hits(wr_addr, OFS_IRQ_MASK)) begin
         next_irq_mask = FLAG_W'(merge(DATA_W'(irq_mask), wr_data, wr_strb)) &
                         FLAG_USED_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask <= FLAG_CLEAR;
      end else begin
         irq_mask <= next_irq_mask;
      end
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; reserved and unmapped bits read zero
   always_comb begin
      rd_data = '0;
      unique case (8'(rd_addr))
         OFS_PART_ID:    rd_data = PART_ID;                                 // see [RULE1]
         OFS_CAUSE:      rd_data = DATA_W'(cause_flags);                    // see [RULE11]
         OFS_PERIPH_RST: rd_data = DATA_W'(ctrl_view);
         OFS_IRQ_STATUS: rd_data = DATA_W'(irq_status);
         OFS_IRQ_MASK:   rd_data = DATA_W'(irq_mask);
         default:        rd_data = '0;
      endcase
   end

endmodule : rcp_top

// file: dv/rcp_top_assertions.sv
// Concurrent checks for the reset cause and part identification bank.
// Assumes rcp_pkg is compiled first; bound to rcp_top by the bind at the foot.
`timescale 1ns/100ps
module rcp_top_assertions #(
   parameter int          ADDR_W  = rcp_pkg::ADDR_W,
   parameter logic [31:0] PART_ID = rcp_pkg::PART_ID_DEFAULT
) (
   input wire logic                       sys_clk,
   input wire logic                       rstn,
   input wire logic                       por_rstn,
   input wire logic                       s_awready,
   input wire logic                       s_awvalid,
   input wire logic [1:0]                 s_bresp,
   input wire logic                       s_bvalid,
   input wire logic                       s_bready,
   input wire logic [ADDR_W-1:0]          s_araddr,
   input wire logic                       s_arvalid,
   input wire logic                       s_arready,
   input wire logic [rcp_pkg::DATA_W-1:0] s_rdata,
   input wire logic [1:0]                 s_rresp,
   input wire logic                       s_rvalid,
   input wire logic                       s_rready,
   input wire logic                       core_flash_reset,
   input wire logic                       chip_reset_request,
   input wire logic                       irq
);
   import rcp_pkg::*;
   localparam logic [7:0] UNMAPPED = 8'h20;
   wire                   ar_take  = s_arvalid && s_arready;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn || !por_rstn);
   ////////////////////////////////////////////////////////////////////////////
   chk_id_read: assert property (ar_take && s_araddr == OFS_PART_ID |=> s_rdata == PART_ID)
      else $error("part id read wrong");
   chk_cause_reserved: assert property (ar_take && s_araddr == OFS_CAUSE |=> s_rdata[31:8] == 24'h0 && !s_rdata[6])
      else $error("reserved cause bits not zero");
   chk_core_pulse: assert property ($rose(core_flash_reset) |-> core_flash_reset[*2] ##1 !core_flash_reset)
      else $error("core reset pulse not two cycles");
   chk_chip_pulse: assert property (chip_reset_request |=> !chip_reset_request)
      else $error("chip reset pulse too long");
   chk_unmapped_read: assert property (ar_take && s_araddr == UNMAPPED |=> s_rresp == RESP_SLVERR && s_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped early");
   chk_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped early");
   chk_read_answer: assert property (ar_take |=> s_rvalid)
      else $error("read answer late");
   // The address slot frees at the write edge, so awready may return while bvalid stands
   chk_aw_blocked: assert property (s_awvalid && s_awready |=> !s_awready)
      else $error("write address taken while one is held");
   // Mask clears on system reset, so irq must stay low even then
   chk_irq_reset: assert property (disable iff (!por_rstn) !rstn |-> !irq)
      else $error("irq high in reset");
   ////////////////////////////////////////////////////////////////////////////
   cov_core: cover property ($rose(core_flash_reset));
   cov_slverr: cover property (s_bvalid && s_bresp == RESP_SLVERR);
   cov_irq: cover property (irq);
   cov_read: cover property (ar_take ##1 s_rvalid && s_rready);
endmodule : rcp_top_assertions

bind rcp_top rcp_top_assertions #(.ADDR_W(ADDR_W), .PART_ID(PART_ID)) chk_u (
   .sys_clk(sys_clk), .rstn(rstn), .por_rstn(por_rstn), .s_awready(s_awready), .s_bresp(s_bresp),
   .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_awvalid(s_awvalid),
   .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
   .core_flash_reset(core_flash_reset), .chip_reset_request(chip_reset_request), .irq(irq));

// file: dv/rcp_top_bench.sv
// Self-checking bench for the reset cause and part identification bank.
// Assumes rcp_pkg, rcp_top and the checker are compiled first; one 50 MHz clock.
`timescale 1ns/100ps
module rcp_top_bench;
   import rcp_pkg::*;
   localparam logic [31:0] ID = 32'h0000_c3e1; // Arbitrary part code
   logic        sys_clk, rstn, por_rstn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic [5:0]  ev;
   wire         awready, wready, bvalid, arready, rvalid, core_rst, chip_req, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          err_total, check_count, core_cnt, chip_cnt;
   logic [7:0]  evmap [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02};

   rcp_top #(.PART_ID(ID)) dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .por_rstn(por_rstn), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
      .system_reset_request(ev[0]), .brownout_reset(ev[1]), .low_voltage_reset(ev[2]),
      .watchdog_reset(ev[3]), .window_watchdog_reset(ev[4]), .external_pin_reset(ev[5]),
      .core_flash_reset(core_rst), .chip_reset_request(chip_req), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Pulse widths counted at every rising edge, independent of the bus tasks
   always @(posedge sys_clk) begin
      if (core_rst === 1'b1) core_cnt++;
      if (chip_req === 1'b1) chip_cnt++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   // Address and data offered together; each released once taken
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1));
      check({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask : wr_chk

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1));
      check(rdata, ed);
      check({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask : rd_chk

   task automatic pulse(input int i);
      @(posedge sys_clk);
      ev <= 6'h01 << i;
      @(posedge sys_clk);
      ev <= 6'h00;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, por_rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, ev} = '0;
      repeat (5) @(posedge sys_clk);
      rstn     <= 1'b1;
      por_rstn <= 1'b1;
      rd_chk(OFS_PART_ID, ID, RESP_OKAY);
      rd_chk(OFS_CAUSE, 32'h1, RESP_OKAY);
      wr_chk(OFS_PART_ID, 32'hffff_ffff, RESP_OKAY);
      rd_chk(OFS_PART_ID, ID, RESP_OKAY);
      $display("Test identity done");
      wr_chk(OFS_CAUSE, 32'h0, RESP_OKAY);
      rd_chk(OFS_CAUSE, 32'h1, RESP_OKAY);
      wr_chk(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      #1 check({31'h0, irq}, 32'h1);
      wr_chk(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
      #1 check({31'h0, irq}, 32'h0);
      wr_chk(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      wr_chk(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
      #1 check({31'h0, irq}, 32'h0);
      wr_chk(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
      wr_chk(OFS_CAUSE, 32'hffff_ffff, RESP_OKAY);
      rd_chk(OFS_CAUSE, 32'h0, RESP_OKAY);
      $display("Test clear and interrupt done");
      for (int i = 0; i < 6; i++) begin
         pulse(i);
         rd_chk(OFS_CAUSE, {24'h0, evmap[i]}, RESP_OKAY);
         wr_chk(OFS_CAUSE, {24'h0, evmap[i]}, RESP_OKAY);
      end
      $display("Test reset sources done");
      core_cnt = 0;
      wr_chk(OFS_PERIPH_RST, 32'h2, RESP_OKAY);
      repeat (4) @(posedge sys_clk);
      check(core_cnt, 32'd2);
      rd_chk(OFS_PERIPH_RST, 32'h0, RESP_OKAY);
      rd_chk(OFS_CAUSE, 32'h80, RESP_OKAY);
      wr_chk(OFS_CAUSE, 32'h80, RESP_OKAY);
      chip_cnt = 0;
      wr_chk(OFS_PERIPH_RST, 32'h1, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      check(chip_cnt, 32'd1);
      rd_chk(OFS_CAUSE, 32'h01, RESP_OKAY);
      wr_chk(OFS_CAUSE, 32'h01, RESP_OKAY);
      $display("Test one-shot controls done");
      // A system reset must not wipe the record of what caused it
      pulse(1);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rd_chk(OFS_CAUSE, 32'h10, RESP_OKAY);
      wr_chk(8'h20, 32'h1, RESP_SLVERR);
      rd_chk(8'h20, 32'h0, RESP_SLVERR);
      $display("Test survival and unmapped done");
      report_and_stop();
   end

   initial begin
      #(20 * 20000);
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule : rcp_top_bench
